// ==== rtl/cgc_pkg.sv ====
package cgc_pkg;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	localparam int         AW             = 8;
	localparam int         DW             = 16;
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_OUT_EN     = 8'h01;
	localparam logic [7:0] REG_POL_INV    = 8'h02;
	localparam logic [7:0] REG_POL_INPH   = 8'h03;
	localparam logic [7:0] REG_OE_MAP     = 8'h04;
	localparam logic [7:0] REG_SPREAD     = 8'h05;
	localparam logic [7:0] REG_STATUS     = 8'h06;
	localparam logic [7:0] REG_ODIV_BASE  = 8'h10;
	localparam logic [7:0] REG_BANK_BASE  = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_SEL_EXT   = 0;
	localparam int CTRL_SEL_PINS  = 1;
	localparam int CTRL_XTAL_OFF  = 2;
	localparam int CTRL_EXT_OFF   = 3;
	localparam int CTRL_RECAL     = 4;
	localparam int CTRL_SPREAD0   = 5;
	localparam int CTRL_SPREAD1   = 6;
	localparam int SPR_CENTER     = 0;
	localparam int SPR_MAG_LSB    = 1;
	localparam int SPR_MAG_W      = 5;
	localparam int STS_RUN        = 0;
	localparam int STS_RECAL      = 1;
	localparam int STS_NOREF      = 2;
	localparam int STS_ACT_EXT    = 3;
	localparam int STS_ADDR_LSB   = 4;
	localparam int STS_LOADED     = 5;
	localparam int ODIV_W         = 6;
	localparam int BANK_W         = 8;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST     = 16'h0000;
	localparam logic [15:0] OUT_EN_RST   = 16'h0fff;
	localparam logic [15:0] POL_RST      = 16'h0000;
	localparam logic [15:0] OE_MAP_RST   = 16'h0fff;
	localparam logic [15:0] SPREAD_RST   = 16'h000a;
	localparam logic [5:0]  ODIV_RST     = 6'h01;
	localparam logic [15:0] BANK_RST     = 16'h0808;
	localparam logic [7:0]  BANK_MIN     = 8'h08;
	localparam logic [4:0]  MAG_MIN      = 5'h01;
	localparam logic [4:0]  MAG_MAX      = 5'h19;
	localparam logic [1:0]  SELPIN_EXT   = 2'h1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 40;
	localparam int RECAL_NS       = 5000;
	localparam int RECAL_CYC      = (RECAL_NS * CLK_MHZ + 999) / 1000;
	localparam int ENABLE_MAX_US  = 20;
	localparam int ENABLE_MAX_CYC = ENABLE_MAX_US * CLK_MHZ;

endpackage

// ==== rtl/cgc_div.sv ====
`timescale 1ns/1ps
// Integer divider: output toggles every div_i ticks, so a tick on every
// edge of the source gives a true divide-by-div_i.
module cgc_div #(
	parameter int W = 6
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         tick_i,
	input  wire logic [W-1:0] div_i,
	input  wire logic         run_i,
	input  wire logic         squelch_i,
	output logic              clk_o,
	output logic              on_o
);
	logic [W-1:0] cnt_q, cnt_d, div_eff;
	logic         clk_q, clk_d, on_q, on_d;

	assign div_eff = (div_i == '0) ? W'(1) : div_i;

	always_comb begin
		cnt_d = cnt_q;
		clk_d = clk_q;
		on_d  = on_q;
		if (squelch_i) begin
			cnt_d = '0;
			clk_d = 1'b0;
			on_d  = 1'b0;
		end else if (!on_q) begin
			if (run_i) begin
				on_d  = 1'b1;
				cnt_d = '0;
			end
		end else if (tick_i) begin
			if (cnt_q >= div_eff - W'(1)) begin
				cnt_d = '0;
				// Stop only on a period boundary: no runt pulse
				if (!run_i && !clk_q) begin
					on_d = 1'b0;
				end else begin
					clk_d = ~clk_q;
					if (!run_i) begin
						on_d = 1'b0;
					end
				end
			end else begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
			on_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
			on_q  <= on_d;
		end
	end

	assign clk_o = clk_q;
	assign on_o  = on_q;

	a_no_runt_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!run_i && !clk_q && !squelch_i) |=> !clk_q)
		else $error("Clock rose while output was being disabled");
	a_stop_is_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$fell(on_q) |-> !clk_q)
		else $error("Divider stopped in the high phase");

endmodule

// ==== rtl/cgc_top.sv ====
`timescale 1ns/1ps
// Operation
// - Software can switch off unused clock inputs
// - Reference chosen by register or pins
// - No reference at power-up keeps outputs off
// - Recalibration turns outputs off, then resumes
// - Near-frequency switch: no recalibration needed
// - Input changes are never masked from outputs
// - Per-output divider one to sixty-three
// - Per-pin polarity, complementary by default
// - Active-low enable pin disables assigned outputs
// - Enabled outputs individually disabled by register
// - Disable waits for the clock period end
// - Center or down spread, 0.1% to 2.5%
// - Spread per divider, by pin or bus
// - Spread pin low off, high on, immediate
// - Five bank dividers, two values, 8-255
// - Bank select pin low first, high second
// - Profile pin switches fractional divider profile
// - Address pin sets bus address low bit
// - Disable within few cycles, enable under 20us
// - True and complement pins switch together
// - Enable pin maps to output, bank, all
// - Outputs squelched until configuration is loaded
module cgc_top #(
	parameter int NOUT  = 12,
	parameter int NBANK = 5
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic [7:0]       addr_i,
	input  wire logic [15:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [15:0]      rdata_o,
	input  wire logic             cfg_loaded_i,
	input  wire logic             xtal_active_i,
	input  wire logic             ext_ref_active_i,
	input  wire logic [1:0]       input_source_select_pins_i,
	input  wire logic             output_enable_low_pin_i,
	input  wire logic             spread_enable_divider_zero_i,
	input  wire logic             spread_enable_divider_one_i,
	input  wire logic [NBANK-1:0] bank_divider_freq_select_i,
	input  wire logic [1:0]       fractional_divider_profile_select_i,
	input  wire logic             bus_address_select_pin_i,
	output logic      [NOUT-1:0]  true_output_pin_o,
	output logic      [NOUT-1:0]  complement_output_pin_o,
	output logic                  xtal_enable_o,
	output logic                  ext_ref_enable_o,
	output logic                  ref_select_ext_o,
	output logic                  vco_recal_o,
	output logic      [1:0]       spread_enable_o,
	output logic                  spread_center_o,
	output logic      [4:0]       spread_magnitude_o,
	output logic      [1:0]       profile_select_o,
	output logic                  bus_address_lsb_o
);
	localparam int NPIN      = 8 + NBANK;
	localparam int RECAL_END = cgc_pkg::RECAL_CYC - 1;
	localparam int EN_MAX    = cgc_pkg::ENABLE_MAX_CYC;

	typedef enum logic [2:0] {
		CGC_INIT, CGC_CHECK, CGC_RUN, CGC_NOREF, CGC_RECAL
	} cgc_state_e;

	function automatic logic [7:0] cgc_bank_clamp(input logic [7:0] v);
		cgc_bank_clamp = (v < cgc_pkg::BANK_MIN) ? cgc_pkg::BANK_MIN : v;
	endfunction

	function automatic logic [4:0] cgc_mag_clamp(input logic [4:0] v);
		if (v < cgc_pkg::MAG_MIN)
			cgc_mag_clamp = cgc_pkg::MAG_MIN;
		else if (v > cgc_pkg::MAG_MAX)
			cgc_mag_clamp = cgc_pkg::MAG_MAX;
		else
			cgc_mag_clamp = v;
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [NPIN-1:0] pin_raw, pin_meta_q, pin_q;
	logic [1:0]       sel_pins;
	logic             oe_low, spr0_pin, spr1_pin, addr_pin;
	logic [NBANK-1:0] fs_pins;
	logic [1:0]       prof_pins;

	assign pin_raw = {bus_address_select_pin_i,
		fractional_divider_profile_select_i, bank_divider_freq_select_i,
		spread_enable_divider_one_i, spread_enable_divider_zero_i,
		output_enable_low_pin_i, input_source_select_pins_i};

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta_q <= '0;
			pin_q      <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q      <= pin_meta_q;
		end
	end

	assign sel_pins  = pin_q[1:0];
	assign oe_low    = pin_q[2];
	assign spr0_pin  = pin_q[3];
	assign spr1_pin  = pin_q[4];
	assign fs_pins   = pin_q[5 +: NBANK];
	assign prof_pins = pin_q[5+NBANK +: 2];
	assign addr_pin  = pin_q[7+NBANK];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] ctrl_q, ctrl_d, outen_q, outen_d, inv_q, inv_d;
	logic [15:0] inph_q, inph_d, oemap_q, oemap_d, spread_q, spread_d;
	logic [15:0] bank_q [NBANK];
	logic [15:0] bank_d [NBANK];
	logic [5:0]  odiv_q [NOUT];
	logic [5:0]  odiv_d [NOUT];
	logic [15:0] rdata_d, status;
	logic        recal_cmd;

	assign recal_cmd = wr_i && (addr_i == cgc_pkg::REG_CTRL)
		&& wdata_i[cgc_pkg::CTRL_RECAL];

	always_comb begin
		ctrl_d   = ctrl_q;
		outen_d  = outen_q;
		inv_d    = inv_q;
		inph_d   = inph_q;
		oemap_d  = oemap_q;
		spread_d = spread_q;
		bank_d   = bank_q;
		odiv_d   = odiv_q;
		if (wr_i) begin
			case (addr_i)
				cgc_pkg::REG_CTRL: begin
					ctrl_d = wdata_i;
					// Recalibration bit is a command, never stored
					ctrl_d[cgc_pkg::CTRL_RECAL] = 1'b0;
				end
				cgc_pkg::REG_OUT_EN:   outen_d = wdata_i;
				cgc_pkg::REG_POL_INV:  inv_d = wdata_i;
				cgc_pkg::REG_POL_INPH: inph_d = wdata_i;
				cgc_pkg::REG_OE_MAP:   oemap_d = wdata_i;
				cgc_pkg::REG_SPREAD:   spread_d = wdata_i;
				default: begin
					for (int i = 0; i < NOUT; i++) begin
						if (addr_i == cgc_pkg::REG_ODIV_BASE + 8'(i))
							odiv_d[i] = wdata_i[5:0];
					end
					for (int b = 0; b < NBANK; b++) begin
						if (addr_i == cgc_pkg::REG_BANK_BASE + 8'(b))
							bank_d[b] = wdata_i;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q   <= cgc_pkg::CTRL_RST;
			outen_q  <= cgc_pkg::OUT_EN_RST;
			inv_q    <= cgc_pkg::POL_RST;
			inph_q   <= cgc_pkg::POL_RST;
			oemap_q  <= cgc_pkg::OE_MAP_RST;
			spread_q <= cgc_pkg::SPREAD_RST;
			for (int b = 0; b < NBANK; b++)
				bank_q[b] <= cgc_pkg::BANK_RST;
			for (int i = 0; i < NOUT; i++)
				odiv_q[i] <= cgc_pkg::ODIV_RST;
		end else begin
			ctrl_q   <= ctrl_d;
			outen_q  <= outen_d;
			inv_q    <= inv_d;
			inph_q   <= inph_d;
			oemap_q  <= oemap_d;
			spread_q <= spread_d;
			bank_q   <= bank_d;
			odiv_q   <= odiv_d;
		end
	end

	// ------------------------------------------------------------
	// Reference selection and recalibration
	// ------------------------------------------------------------
	cgc_state_e state_q, state_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic        sel_ext, ref_ok, running;

	// Source is taken as it stands: a pin change glitches the outputs
	assign sel_ext = ctrl_q[cgc_pkg::CTRL_SEL_PINS]
		? (sel_pins == cgc_pkg::SELPIN_EXT)
		: ctrl_q[cgc_pkg::CTRL_SEL_EXT];
	assign ref_ok = sel_ext
		? (ext_ref_active_i && !ctrl_q[cgc_pkg::CTRL_EXT_OFF])
		: (xtal_active_i && !ctrl_q[cgc_pkg::CTRL_XTAL_OFF]);
	assign running = (state_q == CGC_RUN);

	always_comb begin
		state_d = state_q;
		rcnt_d  = rcnt_q;
		case (state_q)
			CGC_INIT: begin
				if (cfg_loaded_i)
					state_d = CGC_CHECK;
			end
			CGC_CHECK: begin
				state_d = ref_ok ? CGC_RUN : CGC_NOREF;
			end
			// Near-frequency switches stay here; the loop absorbs them
			CGC_RUN, CGC_NOREF: begin
				if (recal_cmd) begin
					state_d = CGC_RECAL;
					rcnt_d  = '0;
				end
			end
			CGC_RECAL: begin
				if (rcnt_q == 16'(RECAL_END))
					state_d = CGC_CHECK;
				else
					rcnt_d = rcnt_q + 16'h0001;
			end
			default: state_d = CGC_INIT;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= CGC_INIT;
			rcnt_q  <= '0;
		end else begin
			state_q <= state_d;
			rcnt_q  <= rcnt_d;
		end
	end

	// ------------------------------------------------------------
	// Bank and output dividers
	// ------------------------------------------------------------
	logic [NBANK-1:0] bclk, bclk_prev_q, btick;
	logic [NOUT-1:0]  oclk, oon, en_eff;
	logic             squelch;

	// Squelch cuts at once: it stands for the loop itself going away
	assign squelch = !running;
	assign btick   = bclk ^ bclk_prev_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			bclk_prev_q <= '0;
		else
			bclk_prev_q <= bclk;
	end

	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		cgc_div #(.W(cgc_pkg::BANK_W)) u_bank (
			.clk_i     (clk_i),
			.nrst_i    (nrst_i),
			.tick_i    (1'b1),
			.div_i     (cgc_bank_clamp(fs_pins[b] ? bank_q[b][15:8]
				: bank_q[b][7:0])),
			.run_i     (1'b1),
			.squelch_i (squelch),
			.clk_o     (bclk[b]),
			.on_o      ()
		);
	end

	for (genvar i = 0; i < NOUT; i++) begin : g_out
		localparam int BK = (i * NBANK) / NOUT;
		// One enable per pair: true and complement stop together
		assign en_eff[i] = outen_q[i]
			&& !(oemap_q[i] && oe_low);
		cgc_div #(.W(cgc_pkg::ODIV_W)) u_odiv (
			.clk_i     (clk_i),
			.nrst_i    (nrst_i),
			.tick_i    (btick[BK]),
			.div_i     (odiv_q[i]),
			.run_i     (en_eff[i]),
			.squelch_i (squelch),
			.clk_o     (oclk[i]),
			.on_o      (oon[i])
		);
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	logic [NOUT-1:0] true_d, comp_d;

	assign true_d = oclk ^ inv_q[NOUT-1:0];
	assign comp_d = ~oclk ^ inv_q[NOUT-1:0] ^ inph_q[NOUT-1:0];

	assign status = {10'h000, state_q != CGC_INIT, addr_pin, sel_ext,
		state_q == CGC_NOREF, state_q == CGC_RECAL, running};

	always_comb begin
		rdata_d = '0;
		if (rd_i) begin
			case (addr_i)
				cgc_pkg::REG_CTRL:     rdata_d = ctrl_q;
				cgc_pkg::REG_OUT_EN:   rdata_d = outen_q;
				cgc_pkg::REG_POL_INV:  rdata_d = inv_q;
				cgc_pkg::REG_POL_INPH: rdata_d = inph_q;
				cgc_pkg::REG_OE_MAP:   rdata_d = oemap_q;
				cgc_pkg::REG_SPREAD:   rdata_d = spread_q;
				cgc_pkg::REG_STATUS:   rdata_d = status;
				default: begin
					for (int i = 0; i < NOUT; i++) begin
						if (addr_i == cgc_pkg::REG_ODIV_BASE + 8'(i))
							rdata_d = {10'h000, odiv_q[i]};
					end
					for (int b = 0; b < NBANK; b++) begin
						if (addr_i == cgc_pkg::REG_BANK_BASE + 8'(b))
							rdata_d = bank_q[b];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o                 <= '0;
			true_output_pin_o       <= '0;
			complement_output_pin_o <= '0;
			xtal_enable_o           <= 1'b0;
			ext_ref_enable_o        <= 1'b0;
			ref_select_ext_o        <= 1'b0;
			vco_recal_o             <= 1'b0;
			spread_enable_o         <= '0;
			spread_center_o         <= 1'b0;
			spread_magnitude_o      <= '0;
			profile_select_o        <= '0;
			bus_address_lsb_o       <= 1'b0;
		end else begin
			rdata_o                 <= rdata_d;
			true_output_pin_o       <= true_d;
			complement_output_pin_o <= comp_d;
			xtal_enable_o    <= !ctrl_q[cgc_pkg::CTRL_XTAL_OFF];
			ext_ref_enable_o <= !ctrl_q[cgc_pkg::CTRL_EXT_OFF];
			ref_select_ext_o <= sel_ext;
			vco_recal_o      <= (state_q == CGC_RECAL);
			spread_enable_o[0] <= spr0_pin
				|| ctrl_q[cgc_pkg::CTRL_SPREAD0];
			spread_enable_o[1] <= spr1_pin
				|| ctrl_q[cgc_pkg::CTRL_SPREAD1];
			spread_center_o <= spread_q[cgc_pkg::SPR_CENTER];
			spread_magnitude_o <= cgc_mag_clamp(
				spread_q[cgc_pkg::SPR_MAG_LSB +: 5]);
			profile_select_o  <= prof_pins;
			bus_address_lsb_o <= addr_pin;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_init_squelch: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == CGC_INIT) |-> (oon == '0))
		else $error("Output running before configuration loaded");
	a_noref_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == CGC_NOREF) |=> (oon == '0))
		else $error("Output running without reference");
	a_recal_length: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(state_q == CGC_RECAL) |-> ##RECAL_END
		(state_q == CGC_RECAL) ##1 (state_q == CGC_CHECK))
		else $error("Recalibration length wrong");
	a_recal_dark: assert property (@(posedge clk_i) disable iff (!nrst_i)
		vco_recal_o |-> (oon == '0))
		else $error("Output running during recalibration");
	a_enable_time: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(en_eff[0] && running && !oon[0]) |-> ##[1:EN_MAX]
		(oon[0] || !en_eff[0] || !running))
		else $error("Enabled output did not start in time");
	a_pin_disable: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(oe_low && oemap_q[0] && !oon[0]) |=> !oon[0])
		else $error("Output restarted while its enable pin was high");
	a_addr_lsb: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$past(bus_address_select_pin_i, 3) == bus_address_lsb_o)
		else $error("Address bit does not follow its pin");
	a_spread_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$past(spread_enable_divider_zero_i, 3) |-> spread_enable_o[0])
		else $error("Spread pin high did not enable spread");
	a_pair_comp: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(running && inv_q[0] == 1'b0 && inph_q[0] == 1'b0) |=>
		(complement_output_pin_o[0] != true_output_pin_o[0]))
		else $error("Default pair is not complementary");
	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(rd_i && addr_i == 8'h0f) |=> (rdata_o == '0))
		else $error("Unmapped read not zero");

endmodule

// ==== verification/cgc_board_model.sv ====
`timescale 1ns/1ps
// Board side: pin drivers, oscillators and the nonvolatile loader.
// Pins are packed as {addr, profile[1:0], bank_fs[4:0], spr1, spr0,
// oe_low, source[1:0]}.
module cgc_board_model #(
	parameter int LOAD_CYC = 20
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        xtal_enable_i,
	input  wire logic        ext_ref_enable_i,
	input  wire logic        xtal_present_i,
	input  wire logic        ext_present_i,
	input  wire logic [12:0] req_i,
	output logic             cfg_loaded_o,
	output logic             xtal_active_o,
	output logic             ext_ref_active_o,
	output logic      [12:0] pins_o
);
	int cnt;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 0;
			cfg_loaded_o <= 1'b0;
			// Source pins already settled on the crystal at power-up
			pins_o <= 13'h0000;
		end else begin
			cnt <= cnt + 1;
			cfg_loaded_o <= cfg_loaded_o | (cnt >= LOAD_CYC);
			pins_o <= req_i;
		end
	end

	// A powered-down or missing oscillator reports no clock
	assign xtal_active_o    = xtal_enable_i & xtal_present_i;
	assign ext_ref_active_o = ext_ref_enable_i & ext_present_i;
endmodule

// ==== verification/clock_gen_input_output_control_tb_top.sv ====
`timescale 1ns/1ps
module clock_gen_input_output_control_tb_top;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic        clk_i   = 1'b0;
	logic        nrst_i  = 1'b1;
	logic [7:0]  addr_i  = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i    = 1'b0;
	logic        rd_i    = 1'b0;
	logic        xp      = 1'b1;
	logic        ep      = 1'b1;
	logic [12:0] req     = 13'h0000;
	logic [12:0] pins;
	logic [15:0] rdata_o;
	logic [11:0] tp;
	logic [11:0] cp;
	logic        cfg, xa, ea, xe, ee, rse, rec, scen, alsb;
	logic [1:0]  sen;
	logic [1:0]  psel;
	logic [4:0]  smag;
	int          err_count   = 0;
	int          comparisons = 0;

	always #12.5 clk_i = ~clk_i;

	cgc_board_model i_board (
		.clk_i(clk_i), .nrst_i(nrst_i),
		.xtal_enable_i(xe), .ext_ref_enable_i(ee),
		.xtal_present_i(xp), .ext_present_i(ep), .req_i(req),
		.cfg_loaded_o(cfg), .xtal_active_o(xa),
		.ext_ref_active_o(ea), .pins_o(pins)
	);

	cgc_top i_dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.cfg_loaded_i(cfg), .xtal_active_i(xa), .ext_ref_active_i(ea),
		.input_source_select_pins_i(pins[1:0]),
		.output_enable_low_pin_i(pins[2]),
		.spread_enable_divider_zero_i(pins[3]),
		.spread_enable_divider_one_i(pins[4]),
		.bank_divider_freq_select_i(pins[9:5]),
		.fractional_divider_profile_select_i(pins[11:10]),
		.bus_address_select_pin_i(pins[12]),
		.true_output_pin_o(tp), .complement_output_pin_o(cp),
		.xtal_enable_o(xe), .ext_ref_enable_o(ee),
		.ref_select_ext_o(rse), .vco_recal_o(rec),
		.spread_enable_o(sen), .spread_center_o(scen),
		.spread_magnitude_o(smag), .profile_select_o(psel),
		.bus_address_lsb_o(alsb)
	);

	// ----------------------------------------------------------
	// Bus and measurement tasks
	// ----------------------------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask

	// Pin path is model flop, two sync flops and an output flop
	task pin(input int b, input logic v);
		@(posedge clk_i);
		req[b] <= v;
		repeat (6) @(negedge clk_i);
	endtask

	// Period between second and third rise; the first may be stale
	task per(input int i, output int p);
		int k;
		int a;
		int n;
		logic pv;
		p = 0;
		a = 0;
		n = 0;
		pv = tp[i];
		for (k = 0; k < 4200 && p == 0; k++) begin
			@(negedge clk_i);
			if (tp[i] === 1'b1 && pv === 1'b0) begin
				n++;
				if (n == 3) p = k - a;
				a = k;
			end
			pv = tp[i];
		end
	endtask

	task recal;
		wr(cgc_pkg::REG_CTRL, 16'h0012);
		repeat (3) @(negedge clk_i);
		chk({15'h0, rec}, 16'h0001, "recal flag");
		chk({4'h0, tp}, 16'h0000, "off in recal");
		repeat (cgc_pkg::RECAL_CYC + 20) @(posedge clk_i);
	endtask

	task spr(input logic [15:0] d, input logic c, input logic [4:0] m);
		wr(cgc_pkg::REG_SPREAD, d);
		repeat (3) @(negedge clk_i);
		chk({10'h0, scen, smag}, {10'h0, c, m}, "spread cfg");
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task t_init;
		logic [15:0] d;
		int p;
		repeat (5) @(negedge clk_i);
		chk({4'h0, tp}, 16'h0000, "squelch true");
		chk({4'h0, cp}, 16'h0fff, "squelch comp");
		chk({14'h0, xe, ee}, 16'h0003, "inputs on");
		for (p = 0; p < 100 && cfg !== 1'b1; p++) @(posedge clk_i);
		repeat (10) @(posedge clk_i);
		rd(cgc_pkg::REG_STATUS, d);
		chk(d & 16'h003f, 16'h0021, "status run");
		rd(cgc_pkg::REG_OUT_EN, d);
		chk(d, cgc_pkg::OUT_EN_RST, "out_en rst");
		rd(cgc_pkg::REG_ODIV_BASE, d);
		chk(d, 16'h0001, "odiv rst");
		rd(cgc_pkg::REG_BANK_BASE + 8'h04, d);
		chk(d, 16'h0808, "bank rst");
		rd(8'h0f, d);
		chk(d, 16'h0000, "unmapped");
		per(0, p);
		chk(16'(p), 16'h0010, "base period");
		$display("test init done");
	endtask

	task t_div;
		int p;
		wr(cgc_pkg::REG_ODIV_BASE, 16'h0003);
		per(0, p);
		chk(16'(p), 16'h0030, "div 3");
		wr(cgc_pkg::REG_ODIV_BASE, 16'h003f);
		per(0, p);
		chk(16'(p), 16'h03f0, "div 63");
		wr(cgc_pkg::REG_ODIV_BASE, 16'h0001);
		wr(cgc_pkg::REG_BANK_BASE, 16'h1003);
		per(0, p);
		chk(16'(p), 16'h0010, "bank clamp");
		pin(5, 1'b1);
		per(0, p);
		chk(16'(p), 16'h0020, "bank b");
		pin(5, 1'b0);
		pin(11, 1'b1);
		pin(12, 1'b1);
		chk({14'h0, psel}, 16'h0002, "profile");
		chk({15'h0, alsb}, 16'h0001, "addr lsb");
		pin(11, 1'b0);
		pin(12, 1'b0);
		$display("test div done");
	endtask

	task t_pol;
		int k;
		for (k = 0; k < 20; k++) begin
			@(negedge clk_i);
			chk({4'h0, cp}, {4'h0, ~tp}, "complement");
		end
		wr(cgc_pkg::REG_POL_INPH, 16'h0001);
		repeat (4) @(posedge clk_i);
		for (k = 0; k < 20; k++) begin
			@(negedge clk_i);
			chk({15'h0, cp[0]}, {15'h0, tp[0]}, "in phase");
		end
		wr(cgc_pkg::REG_POL_INPH, 16'h0000);
		$display("test pol done");
	endtask

	task t_oe;
		int k;
		int w;
		int p;
		@(posedge clk_i);
		req[2] <= 1'b1;
		w = -99;
		for (k = 0; k < 120; k++) begin
			@(negedge clk_i);
			if (tp[0] === 1'b1) begin
				if (w >= 0) w++;
			end else begin
				if (w > 0) chk(16'(w), 16'h0008, "no runt");
				w = 0;
			end
		end
		chk({4'h0, tp}, 16'h0000, "all off");
		chk({4'h0, cp}, 16'h0fff, "pair off");
		pin(2, 1'b0);
		per(0, p);
		chk(16'(p), 16'h0010, "re-enable");
		wr(cgc_pkg::REG_OE_MAP, 16'h0ffe);
		pin(2, 1'b1);
		per(0, p);
		chk(16'(p), 16'h0010, "unmapped runs");
		per(1, p);
		chk(16'(p), 16'h0000, "mapped stops");
		pin(2, 1'b0);
		wr(cgc_pkg::REG_OE_MAP, 16'h0fff);
		wr(cgc_pkg::REG_OUT_EN, 16'h0ffe);
		per(0, p);
		chk(16'(p), 16'h0000, "reg off");
		wr(cgc_pkg::REG_POL_INV, 16'h0001);
		repeat (3) @(negedge clk_i);
		chk({14'h0, cp[0], tp[0]}, 16'h0001, "inverted");
		wr(cgc_pkg::REG_POL_INV, 16'h0000);
		wr(cgc_pkg::REG_OUT_EN, 16'h0fff);
		$display("test oe done");
	endtask

	task t_spr;
		pin(3, 1'b1);
		chk({14'h0, sen}, 16'h0001, "spread pin0");
		pin(4, 1'b1);
		chk({14'h0, sen}, 16'h0003, "spread pin1");
		pin(3, 1'b0);
		pin(4, 1'b0);
		chk({14'h0, sen}, 16'h0000, "spread off");
		wr(cgc_pkg::REG_CTRL, 16'h0040);
		repeat (3) @(negedge clk_i);
		chk({14'h0, sen}, 16'h0002, "spread sw");
		wr(cgc_pkg::REG_CTRL, 16'h0000);
		spr(16'h0033, 1'b1, 5'h19);
		spr(16'h0000, 1'b0, 5'h01);
		spr(16'h003e, 1'b0, 5'h19);
		$display("test spread done");
	endtask

	task t_ref;
		logic [15:0] d;
		int p;
		wr(cgc_pkg::REG_CTRL, 16'h0008);
		repeat (3) @(negedge clk_i);
		chk({14'h0, xe, ee}, 16'h0002, "ext off");
		wr(cgc_pkg::REG_CTRL, 16'h0001);
		repeat (3) @(negedge clk_i);
		chk({14'h0, rse, rec}, 16'h0002, "reg select");
		per(0, p);
		chk(16'(p), 16'h0010, "near switch");
		wr(cgc_pkg::REG_CTRL, 16'h0002);
		pin(0, 1'b1);
		chk({15'h0, rse}, 16'h0001, "pin select");
		pin(0, 1'b0);
		chk({15'h0, rse}, 16'h0000, "pin xtal");
		ep <= 1'b0;
		pin(0, 1'b1);
		recal;
		per(0, p);
		chk(16'(p), 16'h0000, "no ref");
		rd(cgc_pkg::REG_STATUS, d);
		chk(d & 16'h0004, 16'h0004, "noref flag");
		ep <= 1'b1;
		recal;
		per(0, p);
		chk(16'(p), 16'h0010, "resumed");
		$display("test ref done");
	endtask

	// ----------------------------------------------------------
	// Run control
	// ----------------------------------------------------------
	task end_of_test;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		nrst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_init;
		t_div;
		t_pol;
		t_oe;
		t_spr;
		t_ref;
		end_of_test;
	end

	// Whole run needs about 17000 cycles
	initial begin
		repeat (70000) @(posedge clk_i);
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test;
	end
endmodule
